/* File: rtl/cgcfg_top.sv */
`timescale 1ns/1ps
module cgcfg_top #(
   parameter logic [6:0] DEV_ADDR = cgcfg_pkg::DEV_ADDR_DEFAULT,
   parameter int DEB_CYC_2MS = cgcfg_pkg::DEB_CYC_2,
   parameter int DEB_CYC_5S = cgcfg_pkg::DEB_CYC_3
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic comparator_in,
   input wire logic battery_absent_pin,
   input wire logic adapter_present,
   input wire logic battery_below_min,
   input wire logic low_power_mode,
   output logic input_vreg_enable,
   output logic comparator_asserted,
   output logic learn_mode_active,
   output logic otg_enable,
   output logic audio_filter_enable,
   output logic [1:0] freq_select,
   output logic turbo_enable,
   output logic battery_switch_gate,
   output logic current_monitors_enable,
   output logic monitor_select_battery,
   output logic system_power_monitor_enable,
   output logic converter_switching_enable,
   output logic [1:0] low_system_output_threshold,
   output logic discharge_alert_from_field,
   output logic [1:0] discharge_alert_code
);
   import cgcfg_pkg::*;

   logic [SY_N-1:0] sync1;
   logic [SY_N-1:0] sync2;
   logic scl_d;
   logic sda_d;
   logic [15:0] primary;
   logic [15:0] options;
   cgcfg_state_t state;
   logic [3:0] bit_cnt;
   logic [2:0] byte_idx;
   logic [7:0] rx_shift;
   logic [7:0] tx_shift;
   logic [7:0] cmd_q;
   logic [7:0] lo_q;
   logic [7:0] hi_q;
   logic wr_pending;
   logic read_mode;
   logic tx_hi;
   logic master_ack;
   logic [DEB_W-1:0] deb_cnt;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic [7:0] rx_byte;
   logic addr_hit;
   logic cmd_known;
   logic [15:0] rd_word;

   // Debounce limit for a field code
   function automatic logic [DEB_W-1:0] deb_limit(input logic [1:0] code);
      unique case (code)
         2'b00: deb_limit = DEB_W'(DEB_CYC_0);
         2'b01: deb_limit = DEB_W'(DEB_CYC_1);
         2'b10: deb_limit = DEB_W'(DEB_CYC_2MS);
         2'b11: deb_limit = DEB_W'(DEB_CYC_5S);
      endcase
   endfunction : deb_limit

   // Read-back of a register by command code; unknown reads zero
   function automatic logic [15:0] reg_read(input logic [7:0] cmd,
                                            input logic [15:0] p,
                                            input logic [15:0] o);
      if (cmd == CMD_PRIMARY) begin
         reg_read = p;
      end else if (cmd == CMD_OPTIONS) begin
         reg_read = o;
      end else begin
         reg_read = 16'h0000;
      end
   endfunction : reg_read

   // Two-stage synchronisers for every pin; stage one feeds only stage two
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {low_power_mode, battery_below_min, adapter_present,
                   battery_absent_pin, comparator_in, sda_in, scl_in};
         sync2 <= sync1;
      end
   end

   // Previous bus levels for edge and condition detection
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= sync2[SY_SCL];
         sda_d <= sync2[SY_SDA];
      end
   end

   assign scl_rise = sync2[SY_SCL] & ~scl_d;
   assign scl_fall = ~sync2[SY_SCL] & scl_d;
   // Data changing while clock is high marks start and stop
   assign start_ev = sync2[SY_SCL] & scl_d & sda_d & ~sync2[SY_SDA];
   assign stop_ev = sync2[SY_SCL] & scl_d & ~sda_d & sync2[SY_SDA];
   assign rx_byte = rx_shift;
   assign addr_hit = (rx_byte[7:1] == DEV_ADDR);
   assign cmd_known = (rx_byte == CMD_PRIMARY) || (rx_byte == CMD_OPTIONS);
   assign rd_word = reg_read(cmd_q, primary, options); // Word to send back

   // Bus slave: write-word and read-word, low byte first
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state <= ST_IDLE;
         bit_cnt <= '0;
         byte_idx <= '0;
         rx_shift <= '0;
         tx_shift <= '0;
         cmd_q <= '0;
         lo_q <= '0;
         hi_q <= '0;
         wr_pending <= 1'b0;
         read_mode <= 1'b0;
         tx_hi <= 1'b0;
         master_ack <= 1'b0;
         sda_oe <= 1'b0;
      end else if (start_ev) begin
         // Repeated start keeps cmd_q for the read phase
         state <= ST_RX;
         bit_cnt <= '0;
         byte_idx <= BY_ADDR;
         wr_pending <= 1'b0;
         read_mode <= 1'b0;
         tx_hi <= 1'b0;
         sda_oe <= 1'b0;
      end else if (stop_ev) begin
         state <= ST_IDLE;
         wr_pending <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               sda_oe <= 1'b0;
            end
            ST_RX: begin
               if (scl_rise && bit_cnt != BIT_FULL) begin
                  rx_shift <= {rx_shift[6:0], sync2[SY_SDA]};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == BIT_FULL) begin
                  state <= ST_RX_ACK;
                  unique case (byte_idx)
                     BY_ADDR: begin
                        sda_oe <= addr_hit;
                        read_mode <= rx_byte[0];
                        if (!addr_hit) begin
                           state <= ST_IDLE;
                        end
                     end
                     BY_CMD: begin
                        // Unknown command codes are refused
                        sda_oe <= cmd_known;
                        cmd_q <= rx_byte;
                        if (!cmd_known) begin
                           state <= ST_IDLE;
                        end
                     end
                     BY_LO: begin
                        sda_oe <= 1'b1;
                        lo_q <= rx_byte;
                     end
                     BY_HI: begin
                        sda_oe <= 1'b1;
                        hi_q <= rx_byte;
                        wr_pending <= 1'b1;
                     end
                     default: begin
                        // Extra bytes are refused
                        state <= ST_IDLE;
                        sda_oe <= 1'b0;
                     end
                  endcase
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  bit_cnt <= '0;
                  if (read_mode) begin
                     tx_shift <= rd_word[7:0];
                     sda_oe <= ~rd_word[7];
                     state <= ST_TX;
                  end else begin
                     sda_oe <= 1'b0;
                     byte_idx <= byte_idx + 3'h1;
                     state <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == BIT_LAST) begin
                     sda_oe <= 1'b0;
                     state <= ST_TX_ACK;
                  end else begin
                     tx_shift <= {tx_shift[6:0], 1'b0};
                     sda_oe <= ~tx_shift[6];
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  master_ack <= ~sync2[SY_SDA];
               end else if (scl_fall) begin
                  if (master_ack && !tx_hi) begin
                     tx_shift <= rd_word[15:8];
                     sda_oe <= ~rd_word[15];
                     tx_hi <= 1'b1;
                     bit_cnt <= '0;
                     state <= ST_TX;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // Open drain: the line is only ever pulled low
   always_ff @(posedge sys_clk) begin
      sda_out <= 1'b0;
   end

   // Whole word lands at stop, never a half-written field
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         primary <= RST_PRIMARY;
         options <= RST_OPTIONS;
      end else if (stop_ev && wr_pending) begin
         if (cmd_q == CMD_PRIMARY) begin
            primary <= {hi_q, lo_q};
         end else if (cmd_q == CMD_OPTIONS) begin
            options <= {hi_q, lo_q};
         end
      end
   end

   // Comparator assertion debounce; release is immediate
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         deb_cnt <= '0;
         comparator_asserted <= 1'b0;
      end else if (!sync2[SY_CMP]) begin
         deb_cnt <= '0;
         comparator_asserted <= 1'b0;
      end else if (deb_cnt >= deb_limit(primary[P_DEB_HI:P_DEB_LO])) begin
         comparator_asserted <= 1'b1;
      end else begin
         deb_cnt <= deb_cnt + DEB_W'(1);
      end
   end

   // Learn mode, entered with battery present and left on low battery
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         learn_mode_active <= 1'b0;
      end else begin
         learn_mode_active <= primary[P_LEARN_EN]
            & ~sync2[SY_BATABS]
            & ~(primary[P_LEARN_EXIT] & sync2[SY_BELOW]);
      end
   end

   // Steering outputs, registered so every output is a flop
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         input_vreg_enable <= 1'b1;
         otg_enable <= 1'b0;
         audio_filter_enable <= 1'b0;
         freq_select <= 2'b00;
         turbo_enable <= 1'b1;
         battery_switch_gate <= 1'b1;
         current_monitors_enable <= 1'b1;
         monitor_select_battery <= 1'b0;
         system_power_monitor_enable <= 1'b0;
         converter_switching_enable <= 1'b1;
         low_system_output_threshold <= 2'b00;
         discharge_alert_from_field <= 1'b0;
         discharge_alert_code <= 2'b00;
      end else begin
         input_vreg_enable <= ~options[O_VREG_OFF];
         otg_enable <= primary[P_OTG];
         audio_filter_enable <= primary[P_AUDIO];
         freq_select <= primary[P_FREQ_HI:P_FREQ_LO];
         turbo_enable <= ~primary[P_TURBO_OFF];
         // Either turbo or a stopped converter holds the gate on
         battery_switch_gate <= ~primary[P_TURBO_OFF]
            | primary[P_SYS_OFF];
         // Adapter present overrides the disable bit
         current_monitors_enable <= sync2[SY_ADAPT]
            | ~primary[P_MON_OFF];
         monitor_select_battery <= primary[P_MON_SEL];
         system_power_monitor_enable <= primary[P_SYSTEM_POWER_MONITOR_EN];
         converter_switching_enable <= ~primary[P_SYS_OFF];
         low_system_output_threshold <= primary[P_LOWV_HI:P_LOWV_LO];
         discharge_alert_from_field <= ~sync2[SY_ADAPT]
            & sync2[SY_LOWPWR] & ~primary[P_SYSTEM_POWER_MONITOR_EN];
         discharge_alert_code <= options[O_DCA_HI:O_DCA_LO];
      end
   end
endmodule : cgcfg_top

/* File: rtl/cgcfg_pkg.sv */
package cgcfg_pkg;
   // Command codes of the two registers
   localparam logic [7:0] CMD_PRIMARY = 8'h39;
   localparam logic [7:0] CMD_OPTIONS = 8'h3C;
   localparam logic [15:0] RST_PRIMARY = 16'h0000;
   localparam logic [15:0] RST_OPTIONS = 16'h0000;
   // Arbitrary bus address, change per board
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h09;

   // Primary register fields
   localparam int P_DEB_HI = 15;
   localparam int P_DEB_LO = 14;
   localparam int P_LEARN_EXIT = 13;
   localparam int P_LEARN_EN = 12;
   localparam int P_OTG = 11;
   localparam int P_AUDIO = 10;
   localparam int P_FREQ_HI = 9;
   localparam int P_FREQ_LO = 8;
   localparam int P_TURBO_OFF = 6;
   localparam int P_MON_OFF = 5;
   localparam int P_MON_SEL = 4;
   localparam int P_SYSTEM_POWER_MONITOR_EN = 3;
   localparam int P_SYS_OFF = 2;
   localparam int P_LOWV_HI = 1;
   localparam int P_LOWV_LO = 0;
   // Options register fields
   localparam int O_DCA_HI = 4;
   localparam int O_DCA_LO = 3;
   localparam int O_VREG_OFF = 2;

   // Debounce times in microseconds and their cycle counts
   localparam int CLK_MHZ = 25;
   localparam int DEB_US_0 = 2;
   localparam int DEB_US_1 = 12;
   localparam int DEB_US_2 = 2000;
   localparam int DEB_US_3 = 5000000;
   localparam int DEB_CYC_0 = DEB_US_0 * CLK_MHZ;
   localparam int DEB_CYC_1 = DEB_US_1 * CLK_MHZ;
   localparam int DEB_CYC_2 = DEB_US_2 * CLK_MHZ;
   localparam int DEB_CYC_3 = DEB_US_3 * CLK_MHZ;
   localparam int DEB_W = 27;

   // Synchroniser lanes
   localparam int SY_SCL = 0;
   localparam int SY_SDA = 1;
   localparam int SY_CMP = 2;
   localparam int SY_BATABS = 3;
   localparam int SY_ADAPT = 4;
   localparam int SY_BELOW = 5;
   localparam int SY_LOWPWR = 6;
   localparam int SY_N = 7;

   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_FULL = 4'h8;
   localparam logic [2:0] BY_ADDR = 3'h0;
   localparam logic [2:0] BY_CMD = 3'h1;
   localparam logic [2:0] BY_LO = 3'h2;
   localparam logic [2:0] BY_HI = 3'h3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_TX_ACK = 3'b100
   } cgcfg_state_t;
endpackage : cgcfg_pkg

/* File: test/cgcfg_chk.sv */
`timescale 1ns/1ps
module cgcfg_chk (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe,
   input wire logic comparator_in,
   input wire logic battery_absent_pin,
   input wire logic adapter_present,
   input wire logic comparator_asserted,
   input wire logic learn_mode_active,
   input wire logic otg_enable,
   input wire logic audio_filter_enable,
   input wire logic input_vreg_enable,
   input wire logic [1:0] freq_select,
   input wire logic [1:0] low_system_output_threshold,
   input wire logic turbo_enable,
   input wire logic battery_switch_gate,
   input wire logic converter_switching_enable,
   input wire logic current_monitors_enable,
   input wire logic system_power_monitor_enable,
   input wire logic discharge_alert_from_field,
   input wire logic [1:0] discharge_alert_code
);
   import cgcfg_pkg::*;
   int hi_cnt;
   // Comparator high run length, saturated so it never wraps
   always_ff @(posedge sys_clk) begin
      if (srst || !comparator_in) begin
         hi_cnt <= 0;
      end else if (hi_cnt < 1000) begin
         hi_cnt <= hi_cnt + 1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   a_gate_cause: assert property (
      battery_switch_gate == (turbo_enable || !converter_switching_enable))
      else $error("battery gate does not follow turbo or system stop");
   a_mon_adapter: assert property (
      adapter_present [*5] |-> current_monitors_enable
         && !discharge_alert_from_field)
      else $error("adapter present but monitors off or field alert used");
   a_learn_batt: assert property (
      battery_absent_pin [*5] |-> !learn_mode_active)
      else $error("learn mode active without a battery");
   a_deb_clear: assert property (
      !comparator_in [*5] |-> !comparator_asserted)
      else $error("comparator output held after input dropped");
   a_deb_min: assert property (
      $rose(comparator_asserted) |-> hi_cnt >= DEB_CYC_0)
      else $error("comparator asserted before shortest debounce");
   a_sda_change: assert property (
      $changed(sda_oe) |-> !scl_in)
      else $error("data line moved while bus clock high");
   a_cfg_atomic: assert property (
      $changed({otg_enable, audio_filter_enable, freq_select,
         low_system_output_threshold, input_vreg_enable, discharge_alert_code})
         |-> scl_in && sda_in)
      else $error("configuration changed outside a stop");
   a_dca_system_power_monitor: assert property (
      discharge_alert_from_field |-> !system_power_monitor_enable)
      else $error("field alert threshold used with power monitor on");
endmodule : cgcfg_chk

bind cgcfg_top cgcfg_chk cgcfg_chk_i (.*);

/* File: test/cgcfg_host.sv */
`timescale 1ns/1ps
module cgcfg_host (
   input wire logic sys_clk,
   input wire logic sda_oe,
   input wire logic sda_out,
   output logic scl_in,
   output logic sda_in
);
   import cgcfg_pkg::*;
   logic sda_low = 1'b0;
   int ph = 5;
   // Wired line: the device shows its driven level, the pull-up otherwise
   assign sda_in = ~sda_low & (sda_oe ? sda_out : 1'b1);
   initial scl_in = 1'b1;
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt
   // One slot; data moves a cycle after the clock falls, never beside it
   task automatic bit_io(input logic b, output logic r);
      wt(1);
      sda_low <= ~b;
      wt(ph);
      scl_in <= 1'b1;
      wt(ph);
      r = sda_in;
      scl_in <= 1'b0;
   endtask : bit_io
   task automatic start_c();
      wt(1);
      sda_low <= 1'b0;
      wt(ph);
      scl_in <= 1'b1;
      wt(ph);
      sda_low <= 1'b1;
      wt(ph);
      scl_in <= 1'b0;
   endtask : start_c
   // Extra wait lets the commit land before the next start
   task automatic stop_c();
      wt(1);
      sda_low <= 1'b1;
      wt(ph);
      scl_in <= 1'b1;
      wt(ph);
      sda_low <= 1'b0;
      wt(ph + 4);
   endtask : stop_c
   task automatic xfer(input logic [7:0] d, input logic nak,
                       output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(nak, r);
      ack = ~r;
   endtask : xfer
   // Write-word; fewer than four bytes ends the transfer early
   task automatic write_word(input logic [6:0] a, input logic [7:0] c,
                             input logic [15:0] d, input int n,
                             output logic [3:0] acks);
      logic [7:0] b [4];
      logic [7:0] q;
      logic ak;
      if (c == CMD_PRIMARY) d[7] = 1'b0;
      b = '{{a, 1'b0}, c, d[7:0], d[15:8]};
      acks = 4'h0;
      start_c();
      for (int k = 0; k < n; k++) begin
         xfer(b[k], 1'b1, q, ak);
         acks[k] = ak;
      end
      stop_c();
   endtask : write_word
   task automatic read_word(input logic [6:0] a, input logic [7:0] c,
                            output logic [15:0] d, output logic [3:0] acks);
      logic [7:0] q;
      start_c();
      xfer({a, 1'b0}, 1'b1, q, acks[0]);
      xfer(c, 1'b1, q, acks[1]);
      start_c();
      xfer({a, 1'b1}, 1'b1, q, acks[2]);
      xfer(8'hFF, 1'b0, d[7:0], acks[3]);
      xfer(8'hFF, 1'b1, d[15:8], q[0]);
      stop_c();
   endtask : read_word
endmodule : cgcfg_host

/* File: test/cgcfg_top_tb.sv */
`timescale 1ns/1ps
module cgcfg_top_tb;
   import cgcfg_pkg::*;
   localparam int DEB2 = 400;
   localparam int DEB5 = 800;
   localparam int LIMIT = 90000;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic comparator_in = 1'b0;
   logic battery_absent_pin = 1'b0;
   logic adapter_present = 1'b0;
   logic battery_below_min = 1'b0;
   logic low_power_mode = 1'b0;
   logic scl_in, sda_in, sda_out, sda_oe, comparator_asserted;
   logic input_vreg_enable, learn_mode_active, otg_enable;
   logic audio_filter_enable, turbo_enable, battery_switch_gate;
   logic current_monitors_enable, monitor_select_battery;
   logic system_power_monitor_enable, converter_switching_enable;
   logic discharge_alert_from_field;
   logic [1:0] freq_select, low_system_output_threshold, discharge_alert_code;
   logic [15:0] mp = 16'h0000;
   logic [15:0] mo = 16'h0000;
   logic [15:0] rd;
   logic [3:0] ak;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;
   wire logic [16:0] outs = {input_vreg_enable, learn_mode_active,
      otg_enable, audio_filter_enable, freq_select, turbo_enable,
      battery_switch_gate, current_monitors_enable, monitor_select_battery,
      system_power_monitor_enable, converter_switching_enable,
      low_system_output_threshold, discharge_alert_from_field, discharge_alert_code};
   cgcfg_top #(.DEB_CYC_2MS(DEB2), .DEB_CYC_5S(DEB5)) cgcfg_top_i (.*);
   cgcfg_host cgcfg_host_i (.*);
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // s holds adapter, battery absent, below minimum, low power
   function automatic logic [16:0] exp_out(input logic [15:0] p, o,
                                           input logic [3:0] s);
      return {~o[2], p[12] & ~s[2] & ~(p[13] & s[1]), p[11], p[10],
         p[9:8], ~p[6], ~p[6] | p[2], s[3] | ~p[5], p[4], p[3], ~p[2],
         p[1:0], ~s[3] & s[0] & ~p[3], o[4:3]};
   endfunction : exp_out
   function automatic int deb_lim(input logic [1:0] c);
      case (c)
         2'b00: return DEB_CYC_0;
         2'b01: return DEB_CYC_1;
         2'b10: return DEB2;
         default: return DEB5;
      endcase
   endfunction : deb_lim
   task automatic chk(input string nm, input logic [31:0] ex, got);
      comparisons++;
      if (got !== ex) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   // Pins settle through the synchronisers before the look
   task automatic check_cfg(input string nm);
      repeat (6) @(posedge sys_clk);
      chk(nm, 32'(exp_out(mp, mo, {adapter_present, battery_absent_pin,
         battery_below_min, low_power_mode})), 32'(outs));
   endtask : check_cfg
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      cgcfg_host_i.write_word(DEV_ADDR_DEFAULT, c, d, 4, ak);
      chk("write acks", 32'(4'hF), 32'(ak));
      if (c == CMD_PRIMARY) mp = d & 16'hFF7F;
      else mo = d;
   endtask : wr
   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial begin
      logic [15:0] p, o;
      int lim, n;
      void'($urandom(48));
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check_cfg("reset values");
      for (int i = 0; i < 16; i++) begin
         cgcfg_host_i.ph = (i < 2) ? 20 : 5;
         p = 16'($urandom);
         p[9:8] = i[1:0];
         p[1:0] = i[3:2];
         o = 16'($urandom);
         {adapter_present, battery_absent_pin, battery_below_min,
            low_power_mode} <= 4'($urandom);
         wr(CMD_PRIMARY, p);
         wr(CMD_OPTIONS, o);
         check_cfg("fields");
         cgcfg_host_i.read_word(DEV_ADDR_DEFAULT, CMD_PRIMARY, rd, ak);
         chk("read primary", 32'(mp), 32'(rd));
         cgcfg_host_i.read_word(DEV_ADDR_DEFAULT, CMD_OPTIONS, rd, ak);
         chk("read options", 32'(mo), 32'(rd));
      end
      cgcfg_host_i.write_word(DEV_ADDR_DEFAULT ^ 7'h01, CMD_PRIMARY,
         16'hFFFF, 4, ak);
      chk("foreign address", 32'(4'h0), 32'(ak));
      cgcfg_host_i.write_word(DEV_ADDR_DEFAULT, 8'h3A, 16'hFFFF, 4, ak);
      chk("unknown command", 32'(2'b01), 32'(ak[1:0]));
      cgcfg_host_i.write_word(DEV_ADDR_DEFAULT, CMD_PRIMARY, 16'hFFFF, 3, ak);
      check_cfg("cut short");
      for (int c = 0; c < 4; c++) begin
         wr(CMD_PRIMARY, {c[1:0], 14'h0000});
         lim = deb_lim(c[1:0]);
         comparator_in <= 1'b1;
         repeat (lim / 2) @(posedge sys_clk);
         comparator_in <= 1'b0;
         repeat (4) @(posedge sys_clk);
         comparator_in <= 1'b1;
         n = 0;
         // Look between edges so the flop has settled
         while (comparator_asserted !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
         end
         @(posedge sys_clk);
         chk("debounce time", 1, 32'(n >= lim && n <= lim + 6));
         comparator_in <= 1'b0;
         repeat (6) @(posedge sys_clk);
         chk("debounce clear", 0, 32'(comparator_asserted));
      end
      wrap_up();
   end
endmodule : cgcfg_top_tb
